/* acsp_pkg.sv */
// Package for the configuration slave port: widths, decode field, timing.
// Assumes one controller clock and an APB-domain clock enable.
package acsp_pkg;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int DEC_HI      = 11;
  localparam int DEC_LO      = 2;
  localparam int IDX_W       = DEC_HI - DEC_LO + 1;
  localparam int WAIT_CYCLES = 1;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {ACSP_IDLE, ACSP_WAIT, ACSP_DONE} acsp_state_t;
endpackage

/* acsp_store.sv */
// Configuration store behind the slave port, indexed by word address.
// Assumes writes and reads are presented by the port on the same clock.
`timescale 1ns/1ns
module acsp_store #(
  parameter int DEPTH = 1 << acsp_pkg::IDX_W
) (
  input  wire logic                       clk_sys,
  input  wire logic                       wr_en,
  input  wire logic [acsp_pkg::IDX_W-1:0] idx,
  input  wire logic [acsp_pkg::DATA_W-1:0] wdata,
  output logic      [acsp_pkg::DATA_W-1:0] rdata
);
  import acsp_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];

  // No reset on the array: contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[idx] <= wdata;
    end
  end

  assign rdata = mem[idx];
endmodule // acsp_store

/* acsp_port.sv */
// APB slave port reaching the controller configuration space.
// Assumes the bridge follows APB setup/access phases on pclken edges.
`timescale 1ns/1ns
module acsp_port (
  input  wire logic                        clk_sys,
  input  wire logic                        srst,
  input  wire logic                        pclken,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [acsp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [acsp_pkg::DATA_W-1:0] pwdata,
  output logic      [acsp_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr
);
  import acsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // cnt holds the enabled wait edges still to pass before ready
  typedef struct packed {
    acsp_state_t       st;
    logic [1:0]        cnt;
    logic [DATA_W-1:0] rdata;
    logic              ready;
    logic              wr;
    logic              err;
  } acsp_regs_t;

  acsp_regs_t        s_r;
  acsp_regs_t        s_nxt;
  logic [IDX_W-1:0]  idx;
  logic [DATA_W-1:0] store_rd;

  assign idx = paddr[DEC_HI:DEC_LO];

  acsp_store u_store (
    .clk_sys (clk_sys),
    .wr_en   (s_r.wr),
    .idx     (idx),
    .wdata   (pwdata),
    .rdata   (store_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Access phase waits WAIT_CYCLES enabled edges before ready; the store
  // is written once, on the edge after the completing one, while bridge holds address.
  always_comb begin
    s_nxt     = s_r;
    // Write strobe is a one-edge pulse that does not wait on pclken: the
    // bridge still holds address and data on the edge that uses it
    s_nxt.wr  = 1'b0;
    // Error response is tied inactive but still leaves a flip-flop
    s_nxt.err = 1'b0;
    if (pclken) begin
      case (s_r.st)
        ACSP_IDLE: begin
          s_nxt.ready = 1'b0;
          if (psel && penable) begin
            s_nxt.st  = ACSP_WAIT;
            s_nxt.cnt = 2'(WAIT_CYCLES);
          end
        end
        ACSP_WAIT: begin
          // Select lost mid-wait: drop the access, no write and no ready
          if (!psel) begin
            s_nxt.st = ACSP_IDLE;
          end else if (s_r.cnt > 2'h1) begin
            // Further wait states only when WAIT_CYCLES is raised
            s_nxt.cnt = s_r.cnt - 2'h1;
          end else begin
            s_nxt.st    = ACSP_DONE;
            s_nxt.ready = 1'b1;
            s_nxt.wr    = pwrite;
            if (!pwrite) begin
              s_nxt.rdata = store_rd;
            end
          end
        end
        ACSP_DONE: begin
          // Ready stands for one enabled period only
          s_nxt.st    = ACSP_IDLE;
          s_nxt.ready = 1'b0;
        end
        default: begin
          s_nxt.st    = ACSP_IDLE;
          s_nxt.ready = 1'b0;
        end
      endcase
    end
  end

  // Synchronous reset only; the store array is left unreset on purpose
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '{st: ACSP_IDLE, cnt: 2'h0, rdata: RDATA_RST,
               ready: 1'b0, wr: 1'b0, err: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.rdata;
  assign pready  = s_r.ready;
  assign pslverr = s_r.err;

  ////////////////////////////////////////////////////////////////////////
  // Checks on what the port drives; the bus inputs belong to the bridge
  // and are trusted here.
  sequence s_access;
    pclken && psel && penable && !pready;
  endsequence

  // Idle port seeing select and enable together on an enabled edge
  sequence s_taken;
    pclken && psel && penable && s_r.st == ACSP_IDLE;
  endsequence

  // Select lost on an enabled edge while the port still waits
  sequence s_dropped;
    pclken && !psel && s_r.st == ACSP_WAIT;
  endsequence

  property p_err_low;
    @(posedge clk_sys) disable iff (srst) pslverr == 1'b0;
  endproperty
  a_err_low: assert property (p_err_low)
    else $error("error response asserted");

  property p_ready_pulse;
    @(posedge clk_sys) disable iff (srst)
      pready && pclken |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready did not drop after one enabled edge");

  property p_no_early_ready;
    @(posedge clk_sys) disable iff (srst)
      (pclken && !(psel && penable)) ##1 (s_r.st == ACSP_IDLE) |=> !pready;
  endproperty
  a_no_early_ready: assert property (p_no_early_ready)
    else $error("ready raised without access");

  property p_hold_off;
    @(posedge clk_sys) disable iff (srst)
      !pclken |=> $stable(pready) && $stable(prdata);
  endproperty
  a_hold_off: assert property (p_hold_off)
    else $error("outputs moved without clock enable");

  property p_read_data;
    @(posedge clk_sys) disable iff (srst)
      (s_r.st == ACSP_WAIT && pclken && psel && !pwrite && s_r.cnt <= 2'h1)
        |=> pready && prdata == $past(store_rd);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data not returned");

  property p_write_only;
    @(posedge clk_sys) disable iff (srst)
      s_r.wr |-> pready && $past(pwrite);
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("store written on read");

  property p_ready_bound;
    @(posedge clk_sys) disable iff (srst)
      s_access ##1 (pclken && psel && penable)[*2] |-> pready;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("access not completed in time");

  property p_decode;
    @(posedge clk_sys) disable iff (srst)
      idx == paddr[11:2];
  endproperty
  a_decode: assert property (p_decode)
    else $error("decode uses wrong address bits");

  property p_wait_state;
    @(posedge clk_sys) disable iff (srst)
      s_taken |=> !pready && s_r.st == ACSP_WAIT;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("ready raised without a wait state");

  property p_abort;
    @(posedge clk_sys) disable iff (srst)
      s_dropped |=> !pready && !s_r.wr && s_r.st == ACSP_IDLE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("dropped access still completed");

  // Read data stands until the next completed read
  property p_rdata_hold;
    @(posedge clk_sys) disable iff (srst)
      !(s_r.st == ACSP_WAIT && pclken && psel && !pwrite) |=> $stable(prdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved outside a read");

  property p_gated_no_write;
    @(posedge clk_sys) disable iff (srst)
      !pclken |=> !s_r.wr;
  endproperty
  a_gated_no_write: assert property (p_gated_no_write)
    else $error("store written without clock enable");

  property p_write_once;
    @(posedge clk_sys) disable iff (srst)
      s_r.wr |=> !s_r.wr;
  endproperty
  a_write_once: assert property (p_write_once)
    else $error("store written twice for one access");
endmodule // acsp_port

/* acsp_bridge.sv */
// APB bridge model acting as master of the configuration slave port.
// Assumes one clock; the bench owns pclken and reset.
`timescale 1ns/1ns
module acsp_bridge (
  input  wire logic        clk_sys,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] rd, output int n);
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 32);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse so stale values never look valid
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // Write that loses its select one edge after the port takes it, while the port waits
  task automatic abort(input logic [31:0] a, d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // acsp_bridge

/* testbench.sv */
// Testbench for the configuration slave port, one task per scenario.
// Assumes the bridge model drives the bus; pclken is owned here.
`timescale 1ns/1ns
module testbench;
  import acsp_pkg::*;
  logic        clk_sys, srst, pclken, psel, penable, pwrite;
  logic        pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  int          failures, n_tests, n;
  acsp_port dut_u (.clk_sys(clk_sys), .srst(srst), .pclken(pclken),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  acsp_bridge bridge_u (.clk_sys(clk_sys), .prdata(prdata),
    .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    bridge_u.xfer(wr, a, d, rd, n);
    if (n >= 32) begin
      failures++;
      $display("Error at %0t: ready never came", $time);
      give_verdict();
    end else begin
      // Edges after enable: one take, the wait states, one to see ready
      check(n, WAIT_CYCLES + 2);
      check({31'h0, pslverr}, 32'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(prdata, RDATA_RST);
    check({30'h0, pready, pslverr}, 32'h0);
  endtask
  task automatic t_alias();
    xfer(1'b1, 32'h0000_0004, 32'hcafe_0001);
    xfer(1'b1, 32'h0000_0ffc, 32'h1234_5678);
    xfer(1'b0, 32'hffff_f007, 32'h0);
    check(rd, 32'hcafe_0001);
    xfer(1'b0, 32'h8000_0ffd, 32'h0);
    check(rd, 32'h1234_5678);
  endtask
  task automatic t_gate();
    @(posedge clk_sys) pclken <= 1'b0;
    bridge_u.xfer(1'b1, 32'h4, 32'hdead_beef, rd, n);
    check(n, 32);
    @(posedge clk_sys) pclken <= 1'b1;
    xfer(1'b0, 32'h4, 32'h0);
    check(rd, 32'hcafe_0001);
  endtask
  task automatic t_abort();
    bridge_u.abort(32'h0000_0004, 32'h5555_aaaa);
    repeat (4) begin
      @(posedge clk_sys);
      check({31'h0, pready}, 32'h0);
    end
    xfer(1'b0, 32'h4, 32'h0);
    check(rd, 32'hcafe_0001);
  endtask
  initial begin
    failures = 0;
    n_tests = 0;
    srst = 1'b1;
    pclken = 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_alias();
    t_gate();
    t_abort();
    give_verdict();
  end
endmodule // testbench
